// [verilog/elc_pkg.sv]
package elc_pkg;
	// system clock and derived tick rates
	localparam int ELC_CLK_HZ   = 50_000_000;
	localparam int ELC_BASE_HZ  = 65_536;
	localparam int ELC_DIV_W    = 16;
	localparam int ELC_SUB_STEP = 16;
	localparam logic [3:0] ELC_PHASE_LAST = 4'h F;
	localparam int ELC_TRANSFER_US = 244;

	// counter layout
	localparam int ELC_CNT_W = 44;
	localparam int ELC_SUB_W = 12;
	localparam int ELC_SEC_W = 32;
	localparam int ELC_SQ_CNT_W = 17;
	localparam int ELC_SQ_SYNC_LO = 4;

	// register map
	localparam logic [3:0] ELC_A_FRAC_LO = 4'h 0;
	localparam logic [3:0] ELC_A_FRAC_HI = 4'h 1;
	localparam logic [3:0] ELC_A_SEC0    = 4'h 2;
	localparam logic [3:0] ELC_A_SEC3    = 4'h 5;
	localparam logic [3:0] ELC_A_ALM0    = 4'h 6;
	localparam logic [3:0] ELC_A_ALM3    = 4'h 9;
	localparam logic [3:0] ELC_A_CTRL_A  = 4'h A;
	localparam logic [3:0] ELC_A_CTRL_B  = 4'h B;
	localparam logic [3:0] ELC_A_STATUS  = 4'h C;

	// timer_main_control bits
	localparam int ELC_B_TE   = 7;
	localparam int ELC_B_OSC  = 6;
	localparam int ELC_B_SRCH = 5;
	localparam int ELC_B_SRCL = 4;
	localparam int ELC_B_EVENT_INPUT_POLARITY = 3;
	localparam int ELC_B_SQE  = 2;
	localparam int ELC_B_PIE  = 1;
	localparam int ELC_B_AIE  = 0;
	// fraction_low_reg and status bits
	localparam int ELC_B_SYNC = 0;
	localparam int ELC_B_UIP  = 6;
	localparam int ELC_B_PF   = 1;
	localparam int ELC_B_ALM  = 0;

	localparam logic [7:0] ELC_CTRL_RST = 8'h 00;

	// count-source modes
	localparam logic [1:0] ELC_SRC_ALWAYS = 2'b00;
	localparam logic [1:0] ELC_SRC_EVENT  = 2'b01;
	localparam logic [1:0] ELC_SRC_MAIN   = 2'b10;
	localparam logic [1:0] ELC_SRC_BACKUP = 2'b11;

	// periodic code -> low count bits that must roll to zero
	function automatic logic [5:0] elc_pf_bits(input logic [3:0] code);
		case (code)
			4'h 1:   elc_pf_bits = 6'd0;
			4'h 2:   elc_pf_bits = 6'd1;
			4'h 3:   elc_pf_bits = 6'd2;
			4'h 4:   elc_pf_bits = 6'd3;
			4'h 5:   elc_pf_bits = 6'd4;
			4'h 6:   elc_pf_bits = 6'd5;
			4'h 7:   elc_pf_bits = 6'd9;
			4'h 8:   elc_pf_bits = 6'd10;
			4'h 9:   elc_pf_bits = 6'd11;
			4'h A:   elc_pf_bits = 6'd12;
			4'h B:   elc_pf_bits = 6'd18;
			4'h C:   elc_pf_bits = 6'd24;
			4'h D:   elc_pf_bits = 6'd28;
			4'h E:   elc_pf_bits = 6'd31;
			default: elc_pf_bits = 6'd33;
		endcase
	endfunction

	// square code -> prescaler bit index at 65536 Hz toggle rate
	function automatic logic [4:0] elc_sq_bit(input logic [3:0] code);
		if (code == 4'h 0)
			elc_sq_bit = 5'd0;
		else if (code == 4'h 1)
			elc_sq_bit = 5'd2;
		else
			elc_sq_bit = 5'(code) + 5'd1;
	endfunction
endpackage

// [verilog/elc_sq_if.sv]
`timescale 1ns/100ps
interface elc_sq_if;
	logic       tick;
	logic       sync;
	logic [3:0] rate;
	logic       wave;
	modport gen (input tick, input sync, input rate, output wave);
	modport ctl (output tick, output sync, output rate, input wave);
endinterface

// [verilog/elc_sqw.sv]
`timescale 1ns/100ps
module elc_sqw
	import elc_pkg::*;
(
	// clock and reset
	input  wire logic clk_sys,
	input  wire logic rst_b,
	// square-wave control
	elc_sq_if.gen     sq
);
	typedef struct packed {
		logic [ELC_SQ_CNT_W-1:0] cnt;
		logic                    wave;
	} elc_sqw_t;

	elc_sqw_t s_r, s_nxt;

	always_comb begin
		s_nxt = s_r;
		if (sq.tick)
			s_nxt.cnt = s_r.cnt + 1'b1;
		if (sq.sync)
			s_nxt.cnt[ELC_SQ_CNT_W-1:ELC_SQ_SYNC_LO] = '0;
		s_nxt.wave = s_nxt.cnt[elc_sq_bit(sq.rate)];
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b)
			s_r <= '0;
		else
			s_r <= s_nxt;
	end

	assign sq.wave = s_r.wave;

	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_b);

	a_sync_holds_pre: assert property (sq.sync |=> s_r.cnt[ELC_SQ_CNT_W-1:ELC_SQ_SYNC_LO] == '0)
		else $error("square prescaler not held while sync set");
	a_fast_unaffected: assert property (sq.sync && sq.tick |=> s_r.cnt[0] != $past(s_r.cnt[0]))
		else $error("fast square rates stopped by sync");
endmodule // elc_sqw

// [verilog/elc_ctrl_top.sv]
`timescale 1ns/100ps
// Functional notes
// - sync bit 1 clears and holds square prescaler below 4096 Hz; 0 releases it
// - transfer enable copies time to visible copy each 4096 Hz pulse, else frozen
// - oscillator run bit enables oscillator; no fixed start-up latency assumed
// - count source: always, event and main, main only, backup only
// - event polarity picks the active level of the event input
// - square enable drives selected wave, otherwise output held at 0
// - in power fail the square output is released (high impedance)
// - square prescaler is separate; sync aligns it to counter events
// - periodic enable pulls interrupt low while periodic flag set
// - alarm enable pulls interrupt low while alarm flag set
// - rate register: periodic rate bits 7..4, square rate bits 3..0
// - periodic codes 0..10: never, 4096 Hz down to 128 Hz, 8 to 1 Hz
// - periodic codes 11..15: 1/64 down to 1/2097152 Hz
// - square codes: 32768, 8192, then 4096 Hz halving down to 0.5 Hz
// - a status write clears set flags unless an event sets them in that cycle; a set flag ignores new events
// - alarm flag sets when seconds count equals alarm value
module elc_ctrl_top
	import elc_pkg::*;
#(
	parameter int CLK_HZ = ELC_CLK_HZ
) (
	// clock and reset
	input  wire logic       clk_sys,
	input  wire logic       rst_b,
	// byte-wide host bus
	input  wire logic       bus_cs_b,
	input  wire logic       bus_wr_b,
	input  wire logic       bus_rd_b,
	input  wire logic [3:0] bus_addr,
	input  wire logic [7:0] bus_data_i,
	output logic      [7:0] bus_data_o_r,
	output logic            bus_data_oe_r,
	// environment
	input  wire logic       event_input,
	input  wire logic       power_fail_threshold,
	input  wire logic       osc_ok,
	// outputs
	output logic            osc_run_enable_r,
	output logic            irq_o_r,
	output logic            irq_oe_r,
	output logic            square_out_o_r,
	output logic            square_out_oe_r
);
	localparam int TICK_DIV = CLK_HZ / ELC_BASE_HZ;
	localparam logic [ELC_DIV_W-1:0] DIV_LAST = ELC_DIV_W'(TICK_DIV - 1);

	if (TICK_DIV < 2 || TICK_DIV >= (1 << ELC_DIV_W))
		$error("clock rate not served by tick divider");

	typedef struct packed {
		logic [1:0]               cs_sy, wr_sy, rd_sy, ev_sy, pf_sy, ok_sy;
		logic [3:0]               addr_s1, addr_s2;
		logic [7:0]               din_s1, din_s2;
		logic                     wr_q;
		logic [ELC_DIV_W-1:0]     div;
		logic [3:0]               phase;
		logic [7:0]               cta, ctb;
		logic                     sync;
		logic [ELC_CNT_W-1:0]     cnt, copy;
		logic                     dirty;
		logic [ELC_SEC_W-1:0]     alarm;
		logic                     periodic_flag, alarm_match_flag, update_busy_flag;
		logic [7:0]               dout;
		logic                     dout_oe, irq_oe, sq_o, sq_oe;
	} elc_state_t;

	elc_state_t s_r, s_nxt;
	elc_sq_if   sq ();

	logic wr_act, wr_fire, tick65, tick4096, gate, inc, load, te, pf_evt, alm_evt, st_clr;
	logic [ELC_CNT_W-1:0] cnt_inc;

	always_comb begin
		s_nxt = s_r;
		// two-flop synchronisers on all pin inputs
		s_nxt.cs_sy   = {s_r.cs_sy[0], bus_cs_b};
		s_nxt.wr_sy   = {s_r.wr_sy[0], bus_wr_b};
		s_nxt.rd_sy   = {s_r.rd_sy[0], bus_rd_b};
		s_nxt.ev_sy   = {s_r.ev_sy[0], event_input};
		s_nxt.pf_sy   = {s_r.pf_sy[0], power_fail_threshold};
		s_nxt.ok_sy   = {s_r.ok_sy[0], osc_ok};
		s_nxt.addr_s1 = bus_addr;
		s_nxt.addr_s2 = s_r.addr_s1;
		s_nxt.din_s1  = bus_data_i;
		s_nxt.din_s2  = s_r.din_s1;

		wr_act  = !s_r.cs_sy[1] && !s_r.wr_sy[1];
		wr_fire = wr_act && !s_r.wr_q;
		s_nxt.wr_q = wr_act;
		te = s_r.cta[ELC_B_TE];

		// 65536 Hz base tick, only while oscillator runs and reports stable
		tick65 = 1'b0;
		if (s_r.cta[ELC_B_OSC] && s_r.ok_sy[1]) begin
			if (s_r.div == DIV_LAST) begin
				s_nxt.div = '0;
				tick65 = 1'b1;
			end else begin
				s_nxt.div = s_r.div + 1'b1;
			end
		end
		tick4096 = tick65 && (s_r.phase == ELC_PHASE_LAST);
		if (tick65)
			s_nxt.phase = s_r.phase + 1'b1;
		if (tick65 && s_r.phase == ELC_PHASE_LAST - 4'h 1)
			s_nxt.update_busy_flag = 1'b1;
		else if (tick4096)
			s_nxt.update_busy_flag = 1'b0;

		case (s_r.cta[ELC_B_SRCH:ELC_B_SRCL])
			ELC_SRC_ALWAYS: gate = 1'b1;
			ELC_SRC_EVENT:  gate = (s_r.ev_sy[1] == s_r.cta[ELC_B_EVENT_INPUT_POLARITY]) && !s_r.pf_sy[1];
			ELC_SRC_MAIN:   gate = !s_r.pf_sy[1];
			ELC_SRC_BACKUP: gate = s_r.pf_sy[1];
			default:        gate = 1'b0;
		endcase

		// time set: copy written while frozen is loaded when transfer resumes
		load    = wr_fire && s_r.addr_s2 == ELC_A_CTRL_A && s_r.din_s2[ELC_B_TE] && !te && s_r.dirty;
		inc     = tick4096 && gate && !load;
		cnt_inc = s_r.cnt + 1'b1;
		if (load) begin
			s_nxt.cnt   = s_r.copy;
			s_nxt.dirty = 1'b0;
		end else if (inc) begin
			s_nxt.cnt = cnt_inc;
		end
		if (te && tick4096)
			s_nxt.copy = s_nxt.cnt;

		pf_evt  = inc && s_r.ctb[7:4] != 4'h 0 &&
			(cnt_inc & ((ELC_CNT_W'(1) << elc_pf_bits(s_r.ctb[7:4])) - 1'b1)) == '0;
		alm_evt = inc && cnt_inc[ELC_SUB_W-1:0] == '0 &&
			cnt_inc[ELC_CNT_W-1:ELC_SUB_W] == s_r.alarm;
		st_clr  = wr_fire && s_r.addr_s2 == ELC_A_STATUS;

		if (wr_fire) begin
			case (s_r.addr_s2)
				ELC_A_FRAC_LO: begin
					s_nxt.copy[3:0] = s_r.din_s2[7:4];
					s_nxt.sync      = s_r.din_s2[ELC_B_SYNC];
					s_nxt.dirty     = 1'b1;
				end
				ELC_A_FRAC_HI: begin
					s_nxt.copy[ELC_SUB_W-1:4] = s_r.din_s2;
					s_nxt.dirty               = 1'b1;
				end
				ELC_A_CTRL_A: s_nxt.cta = s_r.din_s2;
				ELC_A_CTRL_B: s_nxt.ctb = s_r.din_s2;
				default: begin
					if (s_r.addr_s2 >= ELC_A_SEC0 && s_r.addr_s2 <= ELC_A_SEC3) begin
						s_nxt.copy[ELC_SUB_W + 8 * int'(s_r.addr_s2 - ELC_A_SEC0) +: 8] = s_r.din_s2;
						s_nxt.dirty = 1'b1;
					end else if (s_r.addr_s2 >= ELC_A_ALM0 && s_r.addr_s2 <= ELC_A_ALM3) begin
						s_nxt.alarm[8 * int'(s_r.addr_s2 - ELC_A_ALM0) +: 8] = s_r.din_s2;
					end
				end
			endcase
		end

		// set wins over a clear in the same cycle
		if (pf_evt)
			s_nxt.periodic_flag = 1'b1;
		else if (st_clr)
			s_nxt.periodic_flag = 1'b0;
		if (alm_evt)
			s_nxt.alarm_match_flag = 1'b1;
		else if (st_clr)
			s_nxt.alarm_match_flag = 1'b0;

		// read path
		s_nxt.dout_oe = !s_r.cs_sy[1] && !s_r.rd_sy[1];
		case (s_r.addr_s2)
			ELC_A_FRAC_LO: s_nxt.dout = {s_r.copy[3:0], 3'b000, s_r.sync};
			ELC_A_FRAC_HI: s_nxt.dout = s_r.copy[ELC_SUB_W-1:4];
			ELC_A_CTRL_A:  s_nxt.dout = s_r.cta;
			ELC_A_CTRL_B:  s_nxt.dout = s_r.ctb;
			ELC_A_STATUS: begin
				s_nxt.dout = 8'h 00;
				s_nxt.dout[ELC_B_UIP] = s_r.update_busy_flag;
				s_nxt.dout[ELC_B_PF]  = s_r.periodic_flag;
				s_nxt.dout[ELC_B_ALM] = s_r.alarm_match_flag;
			end
			default: begin
				s_nxt.dout = 8'h 00;
				if (s_r.addr_s2 >= ELC_A_SEC0 && s_r.addr_s2 <= ELC_A_SEC3)
					s_nxt.dout = s_r.copy[ELC_SUB_W + 8 * int'(s_r.addr_s2 - ELC_A_SEC0) +: 8];
				else if (s_r.addr_s2 >= ELC_A_ALM0 && s_r.addr_s2 <= ELC_A_ALM3)
					s_nxt.dout = s_r.alarm[8 * int'(s_r.addr_s2 - ELC_A_ALM0) +: 8];
			end
		endcase

		s_nxt.irq_oe = (s_r.periodic_flag && s_r.cta[ELC_B_PIE]) ||
			(s_r.alarm_match_flag && s_r.cta[ELC_B_AIE]);
		s_nxt.sq_oe = !s_r.pf_sy[1];
		s_nxt.sq_o  = s_r.cta[ELC_B_SQE] && sq.wave;
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			s_r <= '0;
			s_r.cs_sy <= 2'b11;
			s_r.wr_sy <= 2'b11;
			s_r.rd_sy <= 2'b11;
			s_r.cta   <= ELC_CTRL_RST;
			s_r.ctb   <= ELC_CTRL_RST;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign sq.tick = tick65;
	assign sq.sync = s_r.sync;
	assign sq.rate = s_r.ctb[3:0];

	elc_sqw u_sqw (
		.clk_sys (clk_sys),
		.rst_b   (rst_b),
		.sq      (sq)
	);

	assign bus_data_o_r     = s_r.dout;
	assign bus_data_oe_r    = s_r.dout_oe;
	assign osc_run_enable_r = s_r.cta[ELC_B_OSC];
	assign irq_o_r          = s_r.sq_o & 1'b0;
	assign irq_oe_r         = s_r.irq_oe;
	assign square_out_o_r   = s_r.sq_o;
	assign square_out_oe_r  = s_r.sq_oe;

	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_b);

	a_copy_frozen: assert property (!te && !wr_fire |=> $stable(s_r.copy))
		else $error("visible copy changed while transfer disabled");
	a_copy_update: assert property (te && tick4096 |=> s_r.copy == s_r.cnt)
		else $error("visible copy missed a transfer");
	a_osc_stopped: assert property (!s_r.cta[ELC_B_OSC] && !load |=> $stable(s_r.cnt))
		else $error("counter moved with oscillator off");
	a_event_gate: assert property (s_r.cta[ELC_B_SRCH:ELC_B_SRCL] == ELC_SRC_EVENT
		&& s_r.ev_sy[1] != s_r.cta[ELC_B_EVENT_INPUT_POLARITY] && !load |=> $stable(s_r.cnt))
		else $error("counter moved with event input inactive");
	a_sq_low: assert property (!s_r.cta[ELC_B_SQE] |=> !square_out_o_r)
		else $error("square output not held low");
	a_sq_hiz: assert property (s_r.pf_sy[1] |=> !square_out_oe_r)
		else $error("square output driven in power fail");
	a_irq_pf: assert property (s_r.periodic_flag && s_r.cta[ELC_B_PIE] |=> irq_oe_r)
		else $error("periodic interrupt not driven");
	a_irq_alarm: assert property (s_r.alarm_match_flag && s_r.cta[ELC_B_AIE] |=> irq_oe_r)
		else $error("alarm interrupt not driven");
	a_irq_release: assert property (!(s_r.periodic_flag && s_r.cta[ELC_B_PIE]) &&
		!(s_r.alarm_match_flag && s_r.cta[ELC_B_AIE]) |=> !irq_oe_r)
		else $error("interrupt driven with no enabled flag");
	a_flag_sticky: assert property (s_r.periodic_flag && !st_clr |=> s_r.periodic_flag)
		else $error("periodic flag lost without a status write");
	a_pf_set: assert property (pf_evt |=> s_r.periodic_flag)
		else $error("periodic event did not set flag");
	a_alm_set: assert property (alm_evt |=> s_r.alarm_match_flag)
		else $error("alarm match did not set flag");

	c_pf_rise: cover property (!s_r.periodic_flag ##1 s_r.periodic_flag);
	c_alm_rise: cover property (!s_r.alarm_match_flag ##1 s_r.alarm_match_flag);
	c_time_load: cover property (load ##1 s_r.cnt == $past(s_r.copy));
endmodule // elc_ctrl_top

// [tb/elc_host_model.sv]
`timescale 1ns/100ps
module elc_host_model
	import elc_pkg::*;
(
	// clock
	input  wire logic       clk_sys,
	// strobes and address
	output logic            bus_cs_b,
	output logic            bus_wr_b,
	output logic            bus_rd_b,
	output logic      [3:0] bus_addr,
	// data lines
	output logic      [7:0] host_data,
	output logic            host_oe,
	input  wire logic [7:0] dev_data,
	input  wire logic       dev_oe
);
	initial begin
		{bus_cs_b, bus_wr_b, bus_rd_b, host_oe} = 4'b1110;
		bus_addr  = 4'h 0;
		host_data = 8'h 00;
	end

	// address and data held 6 cycles, then 4 idle cycles
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_sys) #1;
		{bus_addr, host_data, host_oe} = {a, d, 1'b1};
		{bus_cs_b, bus_wr_b} = 2'b00;
		repeat (6) @(posedge clk_sys);
		#1;
		{bus_cs_b, bus_wr_b, host_oe} = 3'b110;
		repeat (4) @(posedge clk_sys);
	endtask

	// data taken at the edge where the device enable is seen
	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		int n = 0;
		@(posedge clk_sys) #1;
		bus_addr = a;
		{bus_cs_b, bus_rd_b} = 2'b00;
		do begin
			@(posedge clk_sys);
			n++;
		end while (dev_oe !== 1'b1 && n < 12);
		d = dev_data;
		#1;
		{bus_cs_b, bus_rd_b} = 2'b11;
		repeat (4) @(posedge clk_sys);
	endtask
endmodule // elc_host_model

// [tb/tb.sv]
`timescale 1ns/100ps
module tb
	import elc_pkg::*;
;
	localparam int HZ = 1_000_000;
	localparam int BT = HZ / ELC_BASE_HZ;
	logic       clk_sys, rst_b, ev, pfail, osc_ok, cs_b, wr_b, rd_b, h_oe, d_oe;
	logic       osc_run, irq_o, irq_oe, sq, sq_oe;
	logic [3:0] addr;
	logic [7:0] h_d, d_o, d_i, r1, r2;
	int         bad_count = 0;
	int         checks = 0;

	// undriven bus shows the inverse of the last host value
	assign d_i = d_oe ? d_o : (h_oe ? h_d : ~h_d);

	elc_ctrl_top #(.CLK_HZ(HZ)) elc_ctrl_top_i (
		.clk_sys(clk_sys), .rst_b(rst_b), .bus_cs_b(cs_b), .bus_wr_b(wr_b),
		.bus_rd_b(rd_b), .bus_addr(addr), .bus_data_i(d_i), .bus_data_o_r(d_o),
		.bus_data_oe_r(d_oe), .event_input(ev), .power_fail_threshold(pfail),
		.osc_ok(osc_ok), .osc_run_enable_r(osc_run), .irq_o_r(irq_o), .irq_oe_r(irq_oe),
		.square_out_o_r(sq), .square_out_oe_r(sq_oe)
	);
	elc_host_model elc_host_model_i (
		.clk_sys(clk_sys), .bus_cs_b(cs_b), .bus_wr_b(wr_b), .bus_rd_b(rd_b),
		.bus_addr(addr), .host_data(h_d), .host_oe(h_oe), .dev_data(d_o), .dev_oe(d_oe)
	);

	task automatic wr(input logic [3:0] a, input logic [7:0] d); elc_host_model_i.wr(a, d); endtask
	task automatic rd(input logic [3:0] a, output logic [7:0] d); elc_host_model_i.rd(a, d); endtask
	task automatic cyc(input int n); repeat (n) @(negedge clk_sys); endtask

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic complete_run;
		if (bad_count == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic wait_for(ref logic s, input logic v, input int lim, output int n);
		n = 0;
		while (s !== v && n < lim) begin
			@(negedge clk_sys);
			n++;
		end
	endtask

	task automatic sq_period(output int p);
		int n;
		wait_for(sq, 1'b0, 2000, n);
		wait_for(sq, 1'b1, 2000, n);
		wait_for(sq, 1'b0, 2000, p);
		wait_for(sq, 1'b1, 2000, n);
		p += n;
	endtask

	task automatic t_reset;
		chk(osc_run, 1'b0);
		chk(irq_oe, 1'b0);
		chk(irq_o, 1'b0);
		rd(ELC_A_CTRL_A, r1);
		chk(r1, ELC_CTRL_RST);
		rd(ELC_A_CTRL_B, r1);
		chk(r1, ELC_CTRL_RST);
		wr(4'h D, 8'h FF);
		rd(4'h D, r1);
		chk(r1, 8'h 00);
		wr(ELC_A_CTRL_B, 8'h A5);
		rd(ELC_A_CTRL_B, r1);
		chk(r1, 8'h A5);
		wr(ELC_A_CTRL_A, 8'h 40);
		chk(osc_run, 1'b1);
	endtask

	task automatic t_square;
		int n;
		int f;
		wr(ELC_A_CTRL_B, 8'h 00);
		wait_for(sq, 1'b1, 200, n);
		chk(n, 200);
		wr(ELC_A_CTRL_A, 8'h 44);
		for (int c = 0; c < 5; c++) begin
			wr(ELC_A_CTRL_B, 8'(c));
			f = (c == 0) ? 32768 : (c == 1) ? 8192 : 4096 >> (c - 2);
			sq_period(n);
			chk(n, BT * (ELC_BASE_HZ / f));
		end
		@(posedge clk_sys) #1 pfail = 1'b1;
		cyc(8);
		chk(sq_oe, 1'b0);
		@(posedge clk_sys) #1 pfail = 1'b0;
		cyc(8);
		chk(sq_oe, 1'b1);
	endtask

	task automatic t_sync;
		int n;
		wr(ELC_A_CTRL_B, 8'h 03);
		wr(ELC_A_FRAC_LO, 8'h 01);
		r1[0] = sq;
		wait_for(sq, ~r1[0], 600, n);
		chk(n, 600);
		wr(ELC_A_CTRL_B, 8'h 00);
		sq_period(n);
		chk(n, 2 * BT);
		wr(ELC_A_CTRL_B, 8'h 03);
		wr(ELC_A_FRAC_LO, 8'h 00);
		r1[0] = sq;
		wait_for(sq, ~r1[0], 600, n);
		chk(n < 17 * BT, 1'b1);
	endtask

	task automatic t_count;
		// control A, event, power fail, osc ok, expected flag
		logic [11:0] tc [11] = '{
			{8'h 40, 4'b0000}, {8'h 40, 4'b0011}, {8'h 58, 4'b0010}, {8'h 58, 4'b1011},
			{8'h 50, 4'b0011}, {8'h 50, 4'b1010}, {8'h 58, 4'b1110}, {8'h 60, 4'b0110},
			{8'h 60, 4'b0011}, {8'h 70, 4'b0111}, {8'h 70, 4'b0010}};
		wr(ELC_A_CTRL_B, 8'h 10);
		foreach (tc[i]) begin
			@(posedge clk_sys) #1 {ev, pfail, osc_ok} = tc[i][3:1];
			wr(ELC_A_CTRL_A, tc[i][11:4]);
			wr(ELC_A_STATUS, 8'h 00);
			cyc(34 * BT);
			rd(ELC_A_STATUS, r1);
			chk(r1[ELC_B_PF], tc[i][0]);
		end
		@(posedge clk_sys) #1 {ev, pfail, osc_ok} = 3'b001;
	endtask

	task automatic t_periodic;
		int n;
		longint t0;
		int pc [3] = '{1, 2, 6};
		wr(ELC_A_CTRL_A, 8'h 40);
		wr(ELC_A_CTRL_B, 8'h 10);
		cyc(34 * BT);
		chk(irq_oe, 1'b0);
		wr(ELC_A_CTRL_A, 8'h 42);
		chk(irq_oe, 1'b1);
		foreach (pc[i]) begin
			wr(ELC_A_CTRL_B, 8'(pc[i] << 4));
			wr(ELC_A_STATUS, 8'h 00);
			wait_for(irq_oe, 1'b1, 8000, n);
			// first rise may predate the wait; time two clean rises
			wr(ELC_A_STATUS, 8'h 00);
			wait_for(irq_oe, 1'b1, 8000, n);
			t0 = $time;
			wr(ELC_A_STATUS, 8'h 00);
			wait_for(irq_oe, 1'b1, 8000, n);
			chk(16'(($time - t0) / 20), (16 * BT) << (pc[i] - 1));
		end
		for (int c = 0; c < 12; c += 11) begin
			wr(ELC_A_CTRL_B, 8'(c << 4));
			wr(ELC_A_STATUS, 8'h 00);
			cyc(600);
			chk(irq_oe, 1'b0);
		end
	endtask

	task automatic t_transfer;
		int n;
		logic [7:0] tv [10] = '{8'h F0, 8'h FF, 8'h 44, 8'h 33, 8'h 22, 8'h 11,
			8'h 45, 8'h 33, 8'h 22, 8'h 11};
		wr(ELC_A_CTRL_B, 8'h 00);
		wr(ELC_A_CTRL_A, 8'h C0);
		rd(ELC_A_FRAC_LO, r1);
		cyc(500);
		rd(ELC_A_FRAC_LO, r2);
		chk(r1[7:4] != r2[7:4], 1'b1);
		n = 0;
		do begin
			rd(ELC_A_STATUS, r1);
			n++;
		end while (r1[ELC_B_UIP] !== 1'b0 && n < 20);
		wr(ELC_A_CTRL_A, 8'h 40);
		rd(ELC_A_FRAC_LO, r1);
		cyc(500);
		rd(ELC_A_FRAC_LO, r2);
		chk(r2, r1);
		// fraction all ones, seconds one below the alarm value
		foreach (tv[i])
			wr(4'(i), tv[i]);
		rd(ELC_A_SEC0, r1);
		chk(r1, 8'h 44);
		wr(ELC_A_CTRL_A, 8'h C1);
		wait_for(irq_oe, 1'b1, 16 * BT + 40, n);
		chk(irq_oe, 1'b1);
		cyc(16 * BT + 40);
		rd(ELC_A_STATUS, r1);
		chk(r1[ELC_B_ALM], 1'b1);
		rd(ELC_A_SEC0, r1);
		chk(r1, 8'h 45);
		wr(ELC_A_CTRL_A, 8'h C0);
		chk(irq_oe, 1'b0);
		wr(ELC_A_STATUS, 8'h 00);
		rd(ELC_A_STATUS, r1);
		chk(r1[ELC_B_ALM], 1'b0);
	endtask

	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end

	// whole run is about 37k cycles
	initial begin
		#1_200_000;
		bad_count++;
		complete_run();
	end

	initial begin
		{rst_b, ev, pfail, osc_ok} = 4'b0001;
		repeat (5) @(posedge clk_sys);
		#1 rst_b = 1'b1;
		repeat (3) @(posedge clk_sys);
		t_reset();
		t_square();
		t_sync();
		t_count();
		t_periodic();
		t_transfer();
		complete_run();
	end
endmodule // tb
